/* hw/dsau_top.sv */
// Purpose: dual setpoint alarm unit: tick, setpoint editing, readout flash
// Assumes: buttons arrive as raw pins; all other inputs are on I_CLOCK
// Notes: setpoints and enables are stored here; other settings are ports
//
// Overview of operation
// R1 - two independent channels, each watching speed or run-time hours
// R2 - values compared with setpoints twice per second, regardless of display
// R3 - alarm condition arises when the watched value reaches the setpoint
// R4 - each channel picks high or low function independently
// R5 - output rests open or closed as chosen, opposite when alarm active
// R6 - hysteresis applies only to speed channels
// R7 - configurable delay before the output goes active
// R8 - after accept, output held inactive for the silence time
// R9 - annunciator per channel, blinking during delay or silence
// R10 - flash option alternates readout between value and channel id
// R11 - enable turns a channel on or off, keeping its settings
// R12 - changing monitored quantity restores defaults and clears enable
// R13 - speed setpoint seven digits, hours setpoint five digits
// R14 - digit-by-digit editing: blink digit, up/down change, select advances
// R15 - optional direct setpoint menu from display, guarded by access code
// R16 - high speed alarm releases below setpoint minus hysteresis
// R17 - delay in one-second steps from zero up to 3600 seconds
// R18 - annunciator blinks during delay then stays on when active
// R19 - with nonzero silence, select acts as alarm accept
// R20 - low function alarms at or below the setpoint
// R21 - one half-second tick paces comparison, counting and blinking

module dsau_top
    import dsau_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES
) (
    input wire logic I_CLOCK,
    input wire logic I_RST,
    input wire logic I_BTN_UP,
    input wire logic I_BTN_DOWN,
    input wire logic I_BTN_SELECT,
    input wire logic [VAL_W-1:0] I_SPEED_VALUE,
    input wire logic [HOURS_W-1:0] I_HOURS_VALUE,
    input wire logic [1:0] I_MONITORED_QUANTITY_SELECT,
    input wire logic [1:0] I_HIGH_LOW_SELECT,
    input wire logic [1:0] I_OUTPUT_REST_STATE,
    input wire logic [1:0][VAL_W-1:0] I_HYSTERESIS_AMOUNT,
    input wire logic [1:0][DELAY_W-1:0] I_ACTIVATION_DELAY,
    input wire logic [1:0][DELAY_W-1:0] I_SILENCE_TIME,
    input wire logic [1:0] I_READOUT_FLASH_OPTION,
    input wire logic I_ENABLE_WR,
    input wire logic [1:0] I_ENABLE_VAL,
    input wire logic I_EDIT_REQ,
    input wire logic I_DIRECT_REQ,
    input wire logic I_EDIT_CHANNEL,
    input wire logic I_DIRECT_SETPOINT_MENU,
    input wire logic [CODE_W-1:0] I_ACCESS_CODE,
    output logic [1:0] O_ALARM_SWITCH,
    output logic [1:0] O_ANNUNCIATOR,
    output logic [1:0] O_ALARM_ACTIVE,
    output logic [1:0] O_ENABLE,
    output logic [1:0][BCD_W-1:0] O_SETPOINT,
    output logic O_EDIT_ACTIVE,
    output logic O_CODE_ENTRY,
    output logic [2:0] O_EDIT_DIGIT,
    output logic [BCD_W-1:0] O_EDIT_BUFFER,
    output logic O_DIGIT_BLINK,
    output logic O_READOUT_SHOW_ID,
    output logic O_READOUT_CHANNEL,
    output logic O_TICK
);
    localparam int TW = $clog2(TICK_COUNT);

    typedef struct packed {
        logic [TW-1:0] tick_cnt;
        logic tick;
        logic blink;
        logic flash_ph;
        logic show_id;
        logic show_ch;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] btn_prev;
        logic [1:0] en;
        logic [1:0] qty_prev;
        logic [1:0][BCD_W-1:0] sp;
        dsau_ed_state_t ed;
        logic ed_ch;
        logic [2:0] dig;
        logic [BCD_W-1:0] buf_v;
    } dsau_top_st_t;

    dsau_top_st_t q, d;
    logic [2:0] press;
    logic accept;
    logic [3:0] cur_dig;
    logic [1:0] active, flashing;
    logic [1:0][VAL_W-1:0] sp_bin;

// ----------------------------------------------------------------------------
// tick, buttons, editor, readout
// ----------------------------------------------------------------------------
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.tick_cnt == '0) begin
            d.tick_cnt = TW'(TICK_COUNT - 1); // R21
            d.tick = 1'b1;
        end else begin
            d.tick_cnt = q.tick_cnt - TW'(1);
        end
        if (q.tick) begin
            d.blink = ~q.blink; // R21
            d.flash_ph = ~q.flash_ph;
        end
        // buttons: up, down, select through two stages before use
        d.sync1 = {I_BTN_SELECT, I_BTN_DOWN, I_BTN_UP};
        d.sync2 = q.sync1;
        d.btn_prev = q.sync2;
        press = q.sync2 & ~q.btn_prev;
        accept = press[2] && q.ed == DSAU_ED_IDLE; // R19
        cur_dig = q.buf_v[{q.dig, 2'b00} +: 4];
        if (I_ENABLE_WR) begin
            d.en = I_ENABLE_VAL; // R11
        end
        unique case (q.ed)
            DSAU_ED_IDLE: begin
                if (I_EDIT_REQ || (I_DIRECT_REQ && I_DIRECT_SETPOINT_MENU)) begin // R15
                    d.ed_ch = I_EDIT_CHANNEL;
                    if (I_DIRECT_REQ && !I_EDIT_REQ && I_ACCESS_CODE != '0) begin
                        d.ed = DSAU_ED_CODE; // R15
                        d.buf_v = '0;
                        d.dig = CODE_TOP_DIG;
                    end else begin
                        d.ed = DSAU_ED_EDIT;
                        d.buf_v = q.sp[I_EDIT_CHANNEL];
                        d.dig = I_MONITORED_QUANTITY_SELECT[I_EDIT_CHANNEL]
                            ? HOURS_TOP_DIG : SPEED_TOP_DIG; // R13
                    end
                end
            end
            DSAU_ED_CODE, DSAU_ED_EDIT: begin
                if (press[0]) begin
                    d.buf_v[{q.dig, 2'b00} +: 4] =
                        (cur_dig == BCD_MAX) ? 4'h0 : cur_dig + 4'h1; // R14
                end else if (press[1]) begin
                    d.buf_v[{q.dig, 2'b00} +: 4] =
                        (cur_dig == 4'h0) ? BCD_MAX : cur_dig - 4'h1; // R14
                end else if (press[2] && q.dig != 3'h0) begin
                    d.dig = q.dig - 3'h1; // R14
                end else if (press[2] && q.ed == DSAU_ED_EDIT) begin
                    d.sp[q.ed_ch] = q.buf_v; // R14
                    d.ed = DSAU_ED_IDLE;
                end else if (press[2] && q.buf_v[CODE_W-1:0] == I_ACCESS_CODE) begin
                    d.ed = DSAU_ED_EDIT; // R15
                    d.buf_v = q.sp[q.ed_ch];
                    d.dig = I_MONITORED_QUANTITY_SELECT[q.ed_ch]
                        ? HOURS_TOP_DIG : SPEED_TOP_DIG;
                end else if (press[2]) begin
                    d.ed = DSAU_ED_IDLE; // R15
                end
            end
            default: begin
                d.ed = DSAU_ED_IDLE;
            end
        endcase
        // a quantity change wins over an enable write or a setpoint store
        d.qty_prev = I_MONITORED_QUANTITY_SELECT;
        for (int c = 0; c < 2; c++) begin
            if (I_MONITORED_QUANTITY_SELECT[c] != q.qty_prev[c]) begin
                d.en[c] = 1'b0; // R12
                d.sp[c] = SP_DEFAULT; // R12
            end
        end
        flashing = active & I_READOUT_FLASH_OPTION;
        d.show_id = d.flash_ph & (|flashing); // R10
        d.show_ch = !flashing[0];
    end

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            q <= '{ed: DSAU_ED_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

// ----------------------------------------------------------------------------
// channels
// ----------------------------------------------------------------------------
    // the hours setpoint uses the low five digits; upper digits stay zero
    for (genvar g = 0; g < 2; g++) begin : g_chan
        assign sp_bin[g] = dsau_bcd_to_bin(q.sp[g]);
        dsau_chan u_chan (
            .i_clock(I_CLOCK),
            .i_rst(I_RST),
            .i_tick(q.tick),
            .i_blink(q.blink),
            .i_enable(q.en[g]),
            .i_hours_sel(I_MONITORED_QUANTITY_SELECT[g]),
            .i_high(I_HIGH_LOW_SELECT[g]),
            .i_rest_closed(I_OUTPUT_REST_STATE[g]),
            .i_hyst(I_HYSTERESIS_AMOUNT[g]),
            .i_setpoint(sp_bin[g]),
            .i_speed(I_SPEED_VALUE),
            .i_hours(I_HOURS_VALUE),
            .i_delay(I_ACTIVATION_DELAY[g]),
            .i_silence(I_SILENCE_TIME[g]),
            .i_accept(accept),
            .o_switch_closed(O_ALARM_SWITCH[g]),
            .o_annun(O_ANNUNCIATOR[g]),
            .o_active(active[g])
        );
    end

    assign O_ALARM_ACTIVE = active;
    assign O_ENABLE = q.en;
    assign O_SETPOINT = q.sp;
    assign O_EDIT_ACTIVE = q.ed == DSAU_ED_EDIT;
    assign O_CODE_ENTRY = q.ed == DSAU_ED_CODE;
    assign O_EDIT_DIGIT = q.dig;
    assign O_EDIT_BUFFER = q.buf_v;
    assign O_DIGIT_BLINK = q.blink & (q.ed != DSAU_ED_IDLE); // R14
    assign O_READOUT_SHOW_ID = q.show_id;
    assign O_READOUT_CHANNEL = q.show_ch;
    assign O_TICK = q.tick;

// ----------------------------------------------------------------------------
// checks
// ----------------------------------------------------------------------------
    a_tick_single: assert property (@(posedge I_CLOCK) disable iff (I_RST) // R21
        q.tick |=> !q.tick && q.tick_cnt == TW'(TICK_COUNT - 2))
        else $error("tick not a single pulse");
    a_type_default: assert property (@(posedge I_CLOCK) disable iff (I_RST) // R12
        I_MONITORED_QUANTITY_SELECT[0] != q.qty_prev[0]
        |=> !O_ENABLE[0] && O_SETPOINT[0] == SP_DEFAULT)
        else $error("quantity change kept old settings");
    a_code_reject: assert property (@(posedge I_CLOCK) disable iff (I_RST) // R15
        q.ed == DSAU_ED_CODE && press == 3'h4 && q.dig == 3'h0
        && q.buf_v[CODE_W-1:0] != I_ACCESS_CODE |=> q.ed == DSAU_ED_IDLE)
        else $error("wrong access code accepted");
    a_flash_cause: assert property (@(posedge I_CLOCK) disable iff (I_RST) // R10
        O_READOUT_SHOW_ID |-> $past(|(active & I_READOUT_FLASH_OPTION)))
        else $error("readout flashed without flashing alarm");
endmodule : dsau_top

/* hw/dsau_pkg.sv */
// Purpose: shared constants and types of the dual setpoint alarm unit
// Assumes: 40 MHz system clock, setpoints held as packed bcd digits
// Notes: values compared in binary; bcd ordering is kept by the converter

// ----------------------------------------------------------------------------
// constants
// ----------------------------------------------------------------------------
package dsau_pkg;
    localparam int CLK_FREQ_HZ = 40_000_000;
    localparam int TICK_PERIOD_MS = 500;
    localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
    localparam int VAL_W = 24;
    localparam int HOURS_W = 17;
    localparam int BCD_W = 28;
    localparam int CODE_W = 16;
    localparam int DELAY_W = 12;
    localparam int CNT_W = 13;
    localparam logic [DELAY_W-1:0] DELAY_MAX_S = 12'he10;
    localparam logic [2:0] SPEED_TOP_DIG = 3'h6;
    localparam logic [2:0] HOURS_TOP_DIG = 3'h4;
    localparam logic [2:0] CODE_TOP_DIG = 3'h3;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [BCD_W-1:0] SP_DEFAULT = 28'h0000000;

// ----------------------------------------------------------------------------
// types
// ----------------------------------------------------------------------------
    typedef enum logic [3:0] {
        DSAU_IDLE = 4'h1,
        DSAU_DELAY = 4'h2,
        DSAU_ACTIVE = 4'h4,
        DSAU_SILENT = 4'h8
    } dsau_chan_state_t;

    typedef enum logic [2:0] {
        DSAU_ED_IDLE = 3'h1,
        DSAU_ED_CODE = 3'h2,
        DSAU_ED_EDIT = 3'h4
    } dsau_ed_state_t;

    function automatic logic [VAL_W-1:0] dsau_bcd_to_bin(input logic [BCD_W-1:0] bcd);
        logic [VAL_W-1:0] acc;
        acc = '0;
        for (int i = BCD_W / 4 - 1; i >= 0; i--) begin
            acc = VAL_W'(acc * 24'd10 + {20'h0, bcd[i*4 +: 4]});
        end
        return acc;
    endfunction : dsau_bcd_to_bin
endpackage : dsau_pkg

/* hw/dsau_chan.sv */
// Purpose: one alarm channel: compare, delay, silence, output and annunciator
// Assumes: i_tick is a one-cycle pulse every half second
// Notes: counts run in half-second ticks, so seconds are doubled

module dsau_chan
    import dsau_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_tick,
    input wire logic i_blink,
    input wire logic i_enable,
    input wire logic i_hours_sel,
    input wire logic i_high,
    input wire logic i_rest_closed,
    input wire logic [VAL_W-1:0] i_hyst,
    input wire logic [VAL_W-1:0] i_setpoint,
    input wire logic [VAL_W-1:0] i_speed,
    input wire logic [HOURS_W-1:0] i_hours,
    input wire logic [DELAY_W-1:0] i_delay,
    input wire logic [DELAY_W-1:0] i_silence,
    input wire logic i_accept,
    output logic o_switch_closed,
    output logic o_annun,
    output logic o_active
);
    typedef struct packed {
        dsau_chan_state_t state;
        logic [CNT_W-1:0] cnt;
        logic active;
        logic sw;
        logic ann;
    } dsau_chan_st_t;

    dsau_chan_st_t q, d;
    logic [VAL_W-1:0] val, hy;
    logic [VAL_W:0] sum_v, sum_s;
    logic in_alarm, cond;
    logic [DELAY_W-1:0] dly, sil;

// ----------------------------------------------------------------------------
// comparison and sequencing
// ----------------------------------------------------------------------------
    always_comb begin
        val = i_hours_sel ? {{(VAL_W-HOURS_W){1'b0}}, i_hours} : i_speed; // R1
        hy = i_hours_sel ? '0 : i_hyst; // R6
        in_alarm = q.state != DSAU_IDLE;
        sum_v = {1'b0, val} + {1'b0, hy};
        sum_s = {1'b0, i_setpoint} + {1'b0, hy};
        // once in alarm, release needs the value to clear the hysteresis band
        if (i_high) begin
            cond = in_alarm ? (sum_v >= {1'b0, i_setpoint}) : (val >= i_setpoint); // R3 R16
        end else begin
            cond = in_alarm ? ({1'b0, val} <= sum_s) : (val <= i_setpoint); // R4 R20
        end
        dly = (i_delay > DELAY_MAX_S) ? DELAY_MAX_S : i_delay; // R17
        sil = (i_silence > DELAY_MAX_S) ? DELAY_MAX_S : i_silence;
        d = q;
        if (!i_enable) begin
            d.state = DSAU_IDLE; // R11
            d.cnt = '0;
        end else if (i_tick) begin // R2
            unique case (q.state)
                DSAU_IDLE: begin
                    if (cond && dly == '0) begin
                        d.state = DSAU_ACTIVE;
                    end else if (cond) begin
                        d.state = DSAU_DELAY; // R7
                        d.cnt = {dly, 1'b0};
                    end
                end
                DSAU_DELAY: begin
                    if (!cond) begin
                        d.state = DSAU_IDLE;
                    end else if (q.cnt <= CNT_W'(1)) begin
                        d.state = DSAU_ACTIVE; // R7
                    end else begin
                        d.cnt = q.cnt - CNT_W'(1);
                    end
                end
                DSAU_ACTIVE: begin
                    if (!cond) begin
                        d.state = DSAU_IDLE;
                    end
                end
                DSAU_SILENT: begin
                    if (!cond) begin
                        d.state = DSAU_IDLE;
                    end else if (q.cnt <= CNT_W'(1)) begin
                        d.state = DSAU_ACTIVE; // R8
                    end else begin
                        d.cnt = q.cnt - CNT_W'(1);
                    end
                end
            endcase
        end
        if (i_enable && i_accept && d.state == DSAU_ACTIVE && sil != '0) begin
            d.state = DSAU_SILENT; // R19 R8
            d.cnt = {sil, 1'b0};
        end
        d.active = d.state == DSAU_ACTIVE;
        d.sw = i_rest_closed ^ d.active; // R5
        if (d.state == DSAU_ACTIVE) begin
            d.ann = 1'b1; // R18
        end else begin
            d.ann = (d.state == DSAU_DELAY || d.state == DSAU_SILENT) & i_blink; // R9
        end
    end

    // output rests open under reset, as an unpowered switch would
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            q <= '{state: DSAU_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    assign o_switch_closed = q.sw;
    assign o_annun = q.ann;
    assign o_active = q.active;

// ----------------------------------------------------------------------------
// checks
// ----------------------------------------------------------------------------
    a_zero_delay: assert property (@(posedge i_clock) disable iff (i_rst) // R7
        i_enable && i_tick && q.state == DSAU_IDLE && cond && dly == '0 && !i_accept
        |=> q.state == DSAU_ACTIVE && o_active)
        else $error("zero delay did not activate at once");
    a_annun_steady: assert property (@(posedge i_clock) disable iff (i_rst) // R18
        q.state == DSAU_ACTIVE |-> o_annun)
        else $error("annunciator not steady while active");
    a_silence_hold: assert property (@(posedge i_clock) disable iff (i_rst) // R8
        q.state == DSAU_SILENT && !(i_tick && q.cnt <= CNT_W'(1)) |=> !o_active)
        else $error("output active during silence");
    a_disable_idle: assert property (@(posedge i_clock) disable iff (i_rst) // R11
        !i_enable |=> q.state == DSAU_IDLE && !o_active)
        else $error("disabled channel left idle");
    a_accept_silence: assert property (@(posedge i_clock) disable iff (i_rst) // R19
        i_enable && i_accept && q.state == DSAU_ACTIVE && !i_tick && sil != '0
        |=> q.state == DSAU_SILENT && q.cnt == {$past(sil), 1'b0})
        else $error("accept did not start silence");
endmodule : dsau_chan

/* dv/dsau_ext_circuit.sv */
// Purpose: far-side model of the circuit switched by each alarm output
// Assumes: the circuit knows which switch state its installer chose as rest
// Notes: purely combinational; it only reports what a sounder would see

module dsau_ext_circuit (
    input wire logic [1:0] i_switch_closed,
    input wire logic [1:0] i_rest_closed,
    output logic [1:0] o_alarm_seen
);
    timeunit 1ns;
    timeprecision 100ps;
    // a sounder reacts to any departure from the chosen rest state
    assign o_alarm_seen = i_switch_closed ^ i_rest_closed;
endmodule : dsau_ext_circuit

/* dv/tb_dsau_top.sv */
// Purpose: self-checking bench of the dual setpoint alarm unit
// Assumes: tick shortened to 8 cycles, so one second is 16 cycles
// Notes: buttons are held long enough to pass the pin synchroniser

module tb_dsau_top
    import dsau_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst = 1'b1, up = 1'b0, dn = 1'b0, sel = 1'b0;
    logic [VAL_W-1:0] speed = '0;
    logic [HOURS_W-1:0] hours = 17'h00005;
    logic [1:0] mq = 2'b10, hl = 2'b01, rest = 2'b01, flash = 2'b01;
    logic [1:0][VAL_W-1:0] hyst = {24'h0, 24'h00000a};
    logic [1:0][DELAY_W-1:0] dly = '0, sil = '0;
    logic en_wr = 1'b0, edit_req = 1'b0, edit_ch = 1'b0, dir_req = 1'b0, dir_menu = 1'b0;
    logic [CODE_W-1:0] acc_code = '0;
    logic [1:0] en_val = '0, sw, ann, act, ena, seen;
    logic [1:0][BCD_W-1:0] sp;
    logic ed_act, tick, show_id, rd_ch, code_ent, dig_blink, prev_bit;
    logic [2:0] ed_dig;
    logic [BCD_W-1:0] ed_buf;
    int failures = 0, checks = 0;

    always #12.5 clk = ~clk;

    dsau_top #(.TICK_COUNT(8)) i_dsau_top (
        .I_CLOCK(clk), .I_RST(rst), .I_BTN_UP(up), .I_BTN_DOWN(dn), .I_BTN_SELECT(sel),
        .I_SPEED_VALUE(speed), .I_HOURS_VALUE(hours), .I_MONITORED_QUANTITY_SELECT(mq),
        .I_HIGH_LOW_SELECT(hl), .I_OUTPUT_REST_STATE(rest), .I_HYSTERESIS_AMOUNT(hyst),
        .I_ACTIVATION_DELAY(dly), .I_SILENCE_TIME(sil), .I_READOUT_FLASH_OPTION(flash),
        .I_ENABLE_WR(en_wr), .I_ENABLE_VAL(en_val), .I_EDIT_REQ(edit_req),
        .I_DIRECT_REQ(dir_req), .I_EDIT_CHANNEL(edit_ch), .I_DIRECT_SETPOINT_MENU(dir_menu),
        .I_ACCESS_CODE(acc_code), .O_ALARM_SWITCH(sw), .O_ANNUNCIATOR(ann),
        .O_ALARM_ACTIVE(act), .O_ENABLE(ena), .O_SETPOINT(sp), .O_EDIT_ACTIVE(ed_act),
        .O_CODE_ENTRY(code_ent), .O_EDIT_DIGIT(ed_dig), .O_EDIT_BUFFER(ed_buf),
        .O_DIGIT_BLINK(dig_blink),
        .O_READOUT_SHOW_ID(show_id), .O_READOUT_CHANNEL(rd_ch), .O_TICK(tick)
    );

    dsau_ext_circuit i_dsau_ext_circuit (
        .i_switch_closed(sw), .i_rest_closed(rest), .o_alarm_seen(seen)
    );

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // settle one edge's updates before sampling
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    // tick is looked at off the edge; the design acts on it at the following edge
    task automatic wait_ticks(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            #1;
            while (tick !== 1'b1 && k < 40) begin
                cyc(1);
                k++;
            end
            if (k >= 40) begin
                failures++;
                report_and_stop();
            end
            cyc(1);
        end
        cyc(1);
    endtask : wait_ticks

    // one-cycle editor request, plain or through the direct menu
    task automatic req_pulse(input logic direct);
        @(posedge clk);
        edit_req <= !direct;
        dir_req <= direct;
        @(posedge clk);
        {edit_req, dir_req} <= 2'b00;
        cyc(1);
    endtask : req_pulse

    // 0 up, 1 down, 2 select; held 4 cycles to clear the synchroniser
    task automatic press(input int b);
        @(posedge clk);
        up <= (b == 0);
        dn <= (b == 1);
        sel <= (b == 2);
        repeat (4) @(posedge clk);
        {up, dn, sel} <= 3'b000;
        cyc(4);
    endtask : press

    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask : done

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        cyc(10);
        chk("switch_reset", 2'b00, sw);
        @(posedge clk) rst <= 1'b0;
        cyc(3);
        chk("enable", 2'b00, ena);
        chk("setpoint0", 28'h0, sp[0]);
        done("reset");

        req_pulse(1'b0);
        chk("edit_active", 1'b1, ed_act);
        chk("edit_digit", 3'h6, ed_dig);
        repeat (4) press(2);
        chk("edit_digit", 3'h2, ed_dig);
        press(1);
        chk("edit_buffer", 28'h0000900, ed_buf);
        press(0);
        press(0);
        chk("edit_buffer", 28'h0000100, ed_buf);
        repeat (3) press(2);
        chk("setpoint0", 28'h0000100, sp[0]);
        chk("edit_active", 1'b0, ed_act);
        done("edit");

        @(posedge clk) begin
            en_wr <= 1'b1;
            en_val <= 2'b11;
        end
        @(posedge clk) en_wr <= 1'b0;
        wait_ticks(2);
        chk("enable", 2'b11, ena);
        chk("switch_rest", 2'b01, sw);
        chk("active", 2'b00, act);
        done("enable");

        @(posedge clk) speed <= 24'd150;
        wait_ticks(1);
        chk("active", 2'b01, act);
        chk("switch", 2'b00, sw);
        chk("annunciator", 2'b01, ann);
        chk("circuit_seen", 2'b01, seen);
        wait_ticks(1);
        if (show_id !== 1'b1) begin
            wait_ticks(1);
        end
        chk("show_id", 1'b1, show_id);
        chk("readout_ch", 1'b0, rd_ch);
        done("high");

        @(posedge clk) speed <= 24'd95;
        wait_ticks(2);
        chk("active_hyst", 2'b01, act);
        @(posedge clk) speed <= 24'd89;
        wait_ticks(1);
        chk("active_release", 2'b00, act);
        chk("switch", 2'b01, sw);
        done("hysteresis");

        @(posedge clk) begin
            dly[0] <= 12'h001;
            speed <= 24'd100;
        end
        for (int t = 0; t < 2; t++) begin
            wait_ticks(1);
            chk("active_delay", 2'b00, act);
            if (t == 1) begin
                chk("annun_blink", !prev_bit, ann[0]);
            end
            prev_bit = ann[0];
        end
        wait_ticks(1);
        chk("active_after_delay", 2'b01, act);
        done("delay");

        @(posedge clk) sil[0] <= 12'h002;
        press(2);
        chk("active_silenced", 2'b00, act);
        chk("switch_silenced", 2'b01, sw);
        wait_ticks(2);
        chk("active_still_silenced", 2'b00, act);
        wait_ticks(3);
        chk("active_resumed", 2'b01, act);
        done("silence");

        @(posedge clk) hours <= '0;
        wait_ticks(1);
        chk("active_low", 2'b11, act);
        chk("switch", 2'b10, sw);
        @(posedge clk) mq <= 2'b00;
        cyc(3);
        chk("enable_cleared", 2'b01, ena);
        chk("active_cleared", 2'b01, act);
        done("quantity");

        @(posedge clk) acc_code <= 16'h0001;
        req_pulse(1'b1);
        chk("code_entry_off", 1'b0, code_ent);
        @(posedge clk) dir_menu <= 1'b1;
        req_pulse(1'b1);
        chk("code_entry", 1'b1, code_ent);
        chk("code_digit", 3'h3, ed_dig);
        wait_ticks(1);
        prev_bit = dig_blink;
        wait_ticks(1);
        chk("digit_blink", !prev_bit, dig_blink);
        repeat (4) press(2);
        chk("code_rejected", 1'b0, code_ent);
        chk("edit_refused", 1'b0, ed_act);
        chk("digit_blink_idle", 1'b0, dig_blink);
        req_pulse(1'b1);
        repeat (3) press(2);
        press(0);
        chk("code_buffer", 28'h0000001, ed_buf);
        press(2);
        chk("edit_after_code", 1'b1, ed_act);
        chk("edit_buffer", 28'h0000100, ed_buf);
        chk("edit_digit", 3'h6, ed_dig);
        repeat (7) press(2);
        chk("edit_active", 1'b0, ed_act);
        chk("setpoint0", 28'h0000100, sp[0]);
        chk("active_kept", 2'b01, act);
        done("direct");
        report_and_stop();
    end
endmodule : tb_dsau_top
